/* File: logic/sysctl_pkg.sv */
// constants, field layout and carrier types for the system control block
package sysctl_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_APP_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LOWPOWER = 8'h10;
  localparam logic [7:0] OFS_CORE_CFG = 8'h14;
  localparam logic [7:0] OFS_FAULT_PRI = 8'h18;
  localparam logic [7:0] OFS_SVC_PRI = 8'h1C;
  localparam logic [31:0] LOWPOWER_RESET = 32'h00000000;
  localparam logic [31:0] CORE_CFG_RESET = 32'h00000200;
  localparam logic [31:0] PRI_RESET = 32'h00000000;
  localparam logic [31:0] LOWPOWER_WR_MASK = 32'h00000016;
  localparam logic [31:0] CORE_CFG_WR_MASK = 32'h0000031B;
  localparam logic [31:0] FAULT_PRI_WR_MASK = 32'h00F0F0F0;
  localparam logic [31:0] SVC_PRI_WR_MASK = 32'hF0000000;
  localparam logic [15:0] UNLOCK_KEY = 16'h05FA;
  localparam logic [15:0] UNLOCK_KEY_STAT = 16'hFA05;
  localparam logic [2:0] SPLIT_RESET = 3'h0;
  localparam int SPLIT_LSB = 8;
  localparam int KEY_LSB = 16;
  localparam int BIT_WAKE_ANY = 4;
  localparam int BIT_DEEP = 2;
  localparam int BIT_ON_RETURN = 1;
  localparam int BIT_ALIGN8 = 9;
  localparam int BIT_BF_IGNORE = 8;
  localparam int BIT_DIV_TRAP = 4;
  localparam int BIT_UNAL_TRAP = 3;
  localparam int BIT_UNPRIV_SWT = 1;
  localparam int BIT_THREAD_ANY = 0;
  localparam logic [31:0] ALIGN_STEP = 32'h00000004;

  typedef struct packed {
    logic [7:0] pend_prio;
    logic [7:0] act_prio;
    logic act_valid;
    logic wfe_exec;
    logic sev_exec;
    logic ext_event;
    logic irq_new_pend;
    logic irq_new_enabled;
    logic sleep_req;
    logic return_to_thread;
    logic other_active;
    logic exc_entry;
    logic exception_return_code;
    logic [31:0] sp;
    logic stacked_adj;
    logic top_handler;
    logic data_bus_fault;
    logic div_zero_exec;
    logic unal_hw_word;
    logic unal_multi;
    logic unpriv_swt_wr;
  } core_evt_s;

  typedef struct packed {
    logic preempt;
    logic wfe_waiting;
    logic wake;
    logic lowpower;
    logic deep;
    logic [31:0] sp_out;
    logic stack_adj;
    logic lockup;
    logic bus_fault_ignored;
    logic div_fault;
    logic div_quotient_zero;
    logic usage_fault;
    logic swt_accept;
    logic swt_refuse;
    logic thread_ok;
    logic thread_fault;
  } core_resp_s;

  // group mask over priority bits [7:4]
  function automatic logic [3:0] group_mask(input logic [2:0] split);
    logic [3:0] m;
    m = 4'hF;
    if (split[2]) begin
      m = 4'hF << ({1'b0, split[1:0]} + 3'h1);
    end
    return m;
  endfunction

  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [31:0] be, input logic [31:0] mask);
    return (old & ~(be & mask)) | (dat & be & mask);
  endfunction
endpackage

/* File: logic/core_system_control.sv */
// system control registers, priority grouping, low-power, wake and trap decisions
//
// Behaviour
// - split grouping field selects group and sub bits of each priority nibble
// - preemption compares group priority only, never subpriority
// - wake-on-any-pending lets disabled interrupts going pending wake the core
// - event while not waiting is latched; next wait completes at once
// - send-event instruction or external event input also wakes the core
// - deep select picks sleep or deep sleep, signalled outward on entry
// - lowpower-on-return enters low power on handler to thread return
// - entry aligns stack to 8 or 4 bytes, flags adjust, undone on return
// - top-level handler data bus fault locks up unless ignore bit set
// - zero divisor faults when trap set, else quotient is zero
// - misaligned halfword or word access faults only when trap set
// - misaligned multiple or doubleword access always faults
// - unprivileged software trigger writes only allowed when enable bit set
// - thread return needs no other active exception unless any-level bit set
// - priority fields store upper nibble; low nibble reads zero
// - fault priority register: usage 23:16, bus 15:8, memory 7:0
// - supervisor call priority at 31:24, lower bits reserved
// - priority registers accept byte writes, one byte per field
// - priority fields encode levels 0 to 255 before truncation
// - grouping field at 10:8 written only with key 0x5FA in upper half
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module core_system_control
  import sysctl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_priv_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // core side
  input wire core_evt_s evt,
  output core_resp_s resp
);

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [2:0] split;
    logic [31:0] lowpower_control;
    logic [31:0] core_config_control;
    logic [31:0] fault_handler_priority;
    logic [31:0] supervisor_call_handler_handler_priority;
    logic ev_latch;
    core_resp_s resp;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic [31:0] be;
  logic [3:0] gmask;
  logic wake_src;
  logic req;

  assign wb_ack_o = st_reg.ack;
  assign wb_err_o = st_reg.err;
  assign wb_dat_o = st_reg.rdata;
  assign resp = st_reg.resp;

  always_comb begin
    st_next = st_reg;
    be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    gmask = group_mask(st_reg.split);
    req = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    // register bus
    if (req) begin
      if (!wb_priv_i) begin
        st_next.err = 1'b1;
        st_next.rdata = 32'h00000000;
      end else begin
        st_next.ack = 1'b1;
        if (wb_we_i) begin
          unique case (wb_adr_i)
            OFS_APP_CTRL: begin
              if (wb_sel_i[3] && wb_sel_i[2] && wb_sel_i[1] && wb_dat_i[31:KEY_LSB] == UNLOCK_KEY) begin
                st_next.split = wb_dat_i[SPLIT_LSB+:3];
              end
            end
            OFS_LOWPOWER: begin
              st_next.lowpower_control = wr_merge(st_reg.lowpower_control, wb_dat_i, be, LOWPOWER_WR_MASK);
            end
            OFS_CORE_CFG: begin
              st_next.core_config_control = wr_merge(st_reg.core_config_control, wb_dat_i, be, CORE_CFG_WR_MASK);
            end
            OFS_FAULT_PRI: begin
              st_next.fault_handler_priority = wr_merge(st_reg.fault_handler_priority, wb_dat_i, be,
                                                        FAULT_PRI_WR_MASK);
            end
            OFS_SVC_PRI: begin
              st_next.supervisor_call_handler_handler_priority = wr_merge(st_reg.supervisor_call_handler_handler_priority, wb_dat_i, be,
                                                         SVC_PRI_WR_MASK);
            end
            default: begin
            end
          endcase
          st_next.rdata = 32'h00000000;
        end else begin
          unique case (wb_adr_i)
            OFS_APP_CTRL: st_next.rdata = {UNLOCK_KEY_STAT, 5'h00, st_reg.split, 8'h00};
            OFS_LOWPOWER: st_next.rdata = st_reg.lowpower_control;
            OFS_CORE_CFG: st_next.rdata = st_reg.core_config_control;
            OFS_FAULT_PRI: st_next.rdata = st_reg.fault_handler_priority;
            OFS_SVC_PRI: st_next.rdata = st_reg.supervisor_call_handler_handler_priority;
            default: st_next.rdata = 32'h00000000;
          endcase
        end
      end
    end
    // one-cycle answers
    st_next.resp.wake = 1'b0;
    st_next.resp.bus_fault_ignored = 1'b0;
    st_next.resp.div_fault = 1'b0;
    st_next.resp.div_quotient_zero = 1'b0;
    st_next.resp.usage_fault = 1'b0;
    st_next.resp.swt_accept = 1'b0;
    st_next.resp.swt_refuse = 1'b0;
    st_next.resp.thread_ok = 1'b0;
    st_next.resp.thread_fault = 1'b0;
    st_next.resp.stack_adj = 1'b0;
    // preemption on group bits only
    st_next.resp.preempt = !evt.act_valid ||
                           ((evt.pend_prio[7:4] & gmask) < (evt.act_prio[7:4] & gmask));
    // wait-for-event
    wake_src = evt.sev_exec || evt.ext_event ||
               (evt.irq_new_pend && (evt.irq_new_enabled || st_reg.lowpower_control[BIT_WAKE_ANY]));
    if (st_reg.resp.wfe_waiting) begin
      if (wake_src) begin
        st_next.resp.wfe_waiting = 1'b0;
        st_next.resp.wake = 1'b1;
      end
    end else if (evt.wfe_exec) begin
      if (st_reg.ev_latch || wake_src) begin
        st_next.resp.wake = 1'b1;
        st_next.ev_latch = 1'b0;
      end else begin
        st_next.resp.wfe_waiting = 1'b1;
      end
    end else if (wake_src) begin
      st_next.ev_latch = 1'b1;
    end
    // low-power entry and exit
    if (evt.sleep_req || (evt.return_to_thread && st_reg.lowpower_control[BIT_ON_RETURN])) begin
      st_next.resp.lowpower = 1'b1;
      st_next.resp.deep = st_reg.lowpower_control[BIT_DEEP];
    end else if (wake_src) begin
      st_next.resp.lowpower = 1'b0;
      st_next.resp.deep = 1'b0;
    end
    // stack alignment
    if (evt.exc_entry) begin
      if (st_reg.core_config_control[BIT_ALIGN8]) begin
        st_next.resp.sp_out = {evt.sp[31:3], 3'h0};
        st_next.resp.stack_adj = evt.sp[2];
      end else begin
        st_next.resp.sp_out = {evt.sp[31:2], 2'h0};
      end
    end else if (evt.exception_return_code) begin
      st_next.resp.sp_out = evt.stacked_adj ? (evt.sp | ALIGN_STEP) : evt.sp;
    end
    // bus fault in top handlers
    if (evt.data_bus_fault && evt.top_handler) begin
      if (st_reg.core_config_control[BIT_BF_IGNORE]) begin
        st_next.resp.bus_fault_ignored = 1'b1;
      end else begin
        st_next.resp.lockup = 1'b1;
      end
    end
    // divide by zero
    if (evt.div_zero_exec) begin
      st_next.resp.div_fault = st_reg.core_config_control[BIT_DIV_TRAP];
      st_next.resp.div_quotient_zero = !st_reg.core_config_control[BIT_DIV_TRAP];
    end
    // misaligned access
    st_next.resp.usage_fault = evt.unal_multi ||
                               (evt.unal_hw_word && st_reg.core_config_control[BIT_UNAL_TRAP]);
    // unprivileged software trigger
    if (evt.unpriv_swt_wr) begin
      st_next.resp.swt_accept = st_reg.core_config_control[BIT_UNPRIV_SWT];
      st_next.resp.swt_refuse = !st_reg.core_config_control[BIT_UNPRIV_SWT];
    end
    // thread re-entry
    if (evt.return_to_thread) begin
      if (st_reg.core_config_control[BIT_THREAD_ANY] || !evt.other_active) begin
        st_next.resp.thread_ok = 1'b1;
      end else begin
        st_next.resp.thread_fault = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.split <= SPLIT_RESET;
      st_reg.lowpower_control <= LOWPOWER_RESET;
      st_reg.core_config_control <= CORE_CFG_RESET;
      st_reg.fault_handler_priority <= PRI_RESET;
      st_reg.supervisor_call_handler_handler_priority <= PRI_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_group_only: assert property (
    evt.act_valid && !reset && st_reg.split == 3'h7 |=> !resp.preempt)
    else $error("preempt raised with all bits subpriority");
  chk_split_four: assert property (
    evt.act_valid && st_reg.split == 3'h5 && evt.pend_prio[7:6] == evt.act_prio[7:6] |=> !resp.preempt)
    else $error("subpriority bits affected preemption");
  chk_lower_wins: assert property (
    evt.act_valid && st_reg.split[2] == 1'b0 && evt.pend_prio[7:4] < evt.act_prio[7:4] |=> resp.preempt)
    else $error("more urgent group did not preempt");
  chk_any_pending: assert property (
    resp.wfe_waiting && evt.irq_new_pend && !evt.irq_new_enabled |=>
      resp.wake == $past(st_reg.lowpower_control[BIT_WAKE_ANY]))
    else $error("disabled pending wake does not follow control bit");
  chk_event_latch: assert property (
    !resp.wfe_waiting && !evt.wfe_exec && evt.sev_exec ##1 evt.wfe_exec |=> resp.wake && !resp.wfe_waiting)
    else $error("latched event did not complete wait");
  chk_sev_wake: assert property (
    resp.wfe_waiting && (evt.sev_exec || evt.ext_event) |=> resp.wake && !resp.wfe_waiting)
    else $error("send event did not wake");
  chk_deep_mode: assert property (
    evt.sleep_req |=> resp.lowpower && resp.deep == $past(st_reg.lowpower_control[BIT_DEEP]))
    else $error("low-power mode not signalled");
  chk_return_sleep: assert property (
    evt.return_to_thread && !evt.sleep_req && !wake_src |=>
      resp.lowpower == ($past(st_reg.lowpower_control[BIT_ON_RETURN]) || $past(resp.lowpower)))
    else $error("sleep on return wrong");
  chk_stack_align: assert property (
    evt.exc_entry && st_reg.core_config_control[BIT_ALIGN8] |=> resp.sp_out[2:0] == 3'h0 &&
      resp.stack_adj == $past(evt.sp[2]))
    else $error("stack not aligned to eight bytes");
  chk_lockup_hold: assert property (
    evt.data_bus_fault && evt.top_handler && !st_reg.core_config_control[BIT_BF_IGNORE] |=> resp.lockup [*3])
    else $error("lock-up missing or not held");
  chk_div_zero: assert property (
    evt.div_zero_exec |=> resp.div_fault != resp.div_quotient_zero)
    else $error("divide by zero answer wrong");
  chk_unal_multi: assert property (
    evt.unal_multi |=> resp.usage_fault)
    else $error("misaligned multiple access not faulted");
  chk_swt_gate: assert property (
    evt.unpriv_swt_wr && !st_reg.core_config_control[BIT_UNPRIV_SWT] |=> resp.swt_refuse && !resp.swt_accept)
    else $error("unprivileged trigger not refused");
  chk_thread_gate: assert property (
    evt.return_to_thread && evt.other_active && !st_reg.core_config_control[BIT_THREAD_ANY] |=> resp.thread_fault)
    else $error("thread return allowed with active exception");
  chk_key_guard: assert property (
    req && wb_priv_i && wb_we_i && wb_adr_i == OFS_APP_CTRL && wb_dat_i[31:KEY_LSB] != UNLOCK_KEY |=>
      $stable(st_reg.split))
    else $error("grouping written without key");
  chk_priv_error: assert property (
    req && !wb_priv_i |=> wb_err_o && !wb_ack_o ##1 !wb_err_o)
    else $error("unprivileged access not errored");
  chk_low_nibble: assert property (
    st_reg.fault_handler_priority[3:0] == 4'h0 && st_reg.supervisor_call_handler_handler_priority[27:0] == 28'h0)
    else $error("unimplemented priority bits set");
  chk_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_err_once: assert property (
    wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
  chk_priv_ack: assert property (
    req && wb_priv_i |=> wb_ack_o && !wb_err_o)
    else $error("privileged access not acknowledged");
  chk_err_nocfg: assert property (
    req && !wb_priv_i |=> $stable(st_reg.core_config_control))
    else $error("unprivileged write changed config");
  chk_err_nolp: assert property (
    req && !wb_priv_i |=> $stable(st_reg.lowpower_control))
    else $error("unprivileged write changed low-power control");
  chk_err_nopri: assert property (
    req && !wb_priv_i |=> $stable(st_reg.fault_handler_priority) && $stable(st_reg.supervisor_call_handler_handler_priority))
    else $error("unprivileged write changed priorities");
  chk_err_nosplit: assert property (
    req && !wb_priv_i |=> $stable(st_reg.split))
    else $error("unprivileged write changed grouping");
  chk_lp_reserved: assert property (
    (st_reg.lowpower_control & ~LOWPOWER_WR_MASK) == 32'h00000000)
    else $error("low-power reserved bits set");
  chk_cfg_reserved: assert property (
    (st_reg.core_config_control & ~CORE_CFG_WR_MASK) == 32'h00000000)
    else $error("config reserved bits set");
  chk_fault_bits: assert property (
    (st_reg.fault_handler_priority & ~FAULT_PRI_WR_MASK) == 32'h00000000)
    else $error("fault priority unimplemented bits set");
  chk_svc_bits: assert property (
    (st_reg.supervisor_call_handler_handler_priority & ~SVC_PRI_WR_MASK) == 32'h00000000)
    else $error("supervisor priority reserved bits set");
  chk_split_read: assert property (
    req && wb_priv_i && !wb_we_i && wb_adr_i == OFS_APP_CTRL |=> wb_dat_o[31:KEY_LSB] == UNLOCK_KEY_STAT)
    else $error("grouping read key status wrong");
  chk_key_write: assert property (
    req && wb_priv_i && wb_we_i && wb_adr_i == OFS_APP_CTRL && wb_sel_i[3:1] == 3'h7 &&
      wb_dat_i[31:KEY_LSB] == UNLOCK_KEY |=> st_reg.split == $past(wb_dat_i[SPLIT_LSB+:3]))
    else $error("keyed grouping write lost");
  chk_byte_lane: assert property (
    req && wb_priv_i && wb_we_i && wb_adr_i == OFS_FAULT_PRI && !wb_sel_i[0] |=>
      $stable(st_reg.fault_handler_priority[7:0]))
    else $error("unselected priority byte written");
  chk_write_rdata: assert property (
    req && wb_we_i |=> wb_dat_o == 32'h00000000)
    else $error("read data not zero on write");
  chk_wait_stays: assert property (
    resp.wfe_waiting && !wake_src |=> resp.wfe_waiting && !resp.wake)
    else $error("wait ended without wake source");
  chk_wait_entry: assert property (
    !resp.wfe_waiting && evt.wfe_exec && !st_reg.ev_latch && !wake_src |=> resp.wfe_waiting)
    else $error("wait not entered");
  chk_latch_set: assert property (
    !resp.wfe_waiting && !evt.wfe_exec && wake_src |=> st_reg.ev_latch)
    else $error("event not latched");
  chk_lp_exit: assert property (
    !evt.sleep_req && !evt.return_to_thread && wake_src |=> !resp.lowpower && !resp.deep)
    else $error("low power not left on wake");
  chk_shallow: assert property (
    evt.sleep_req && !st_reg.lowpower_control[BIT_DEEP] |=> !resp.deep)
    else $error("deep signalled for ordinary sleep");
  chk_align_four: assert property (
    evt.exc_entry && !st_reg.core_config_control[BIT_ALIGN8] |=> resp.sp_out[1:0] == 2'h0 && !resp.stack_adj)
    else $error("stack not aligned to four bytes");
  chk_bf_ignore: assert property (
    evt.data_bus_fault && evt.top_handler && st_reg.core_config_control[BIT_BF_IGNORE] |=> resp.bus_fault_ignored)
    else $error("bus fault not ignored");
  chk_div_trap: assert property (
    evt.div_zero_exec && st_reg.core_config_control[BIT_DIV_TRAP] |=> resp.div_fault && !resp.div_quotient_zero)
    else $error("divide by zero not trapped");
  chk_unal_trap: assert property (
    evt.unal_hw_word && st_reg.core_config_control[BIT_UNAL_TRAP] |=> resp.usage_fault)
    else $error("misaligned access not trapped");
  chk_swt_allow: assert property (
    evt.unpriv_swt_wr && st_reg.core_config_control[BIT_UNPRIV_SWT] |=> resp.swt_accept && !resp.swt_refuse)
    else $error("unprivileged trigger not accepted");
  chk_thread_any: assert property (
    evt.return_to_thread && st_reg.core_config_control[BIT_THREAD_ANY] |=> resp.thread_ok)
    else $error("any-level thread return refused");
  chk_equal_group: assert property (
    evt.act_valid && evt.pend_prio[7:4] == evt.act_prio[7:4] |=> !resp.preempt)
    else $error("equal group preempted");

  cov_wfe_sleep: cover property (evt.wfe_exec ##1 resp.wfe_waiting ##[1:20] resp.wake);
  cov_key_write: cover property (req && wb_we_i && wb_adr_i == OFS_APP_CTRL ##1 st_reg.split != $past(st_reg.split));
  cov_byte_pri: cover property (req && wb_we_i && wb_adr_i == OFS_FAULT_PRI && wb_sel_i == 4'h2);
  cov_lockup: cover property (resp.lockup);
endmodule

/* File: bench/core_system_control_tb.sv */
// self-checking bench for the system control block
`timescale 1ns/1ps
module core_system_control_tb;
  import sysctl_pkg::*;
  localparam int WAIT_FOR_EVENT_INSTR = 0, SEND_EVENT_INSTR = 1, EXT = 2, IRQ = 3, SLP = 4, RET = 5, ENT = 6;
  localparam int XRT = 7, BUS = 8, DIV = 9, UNH = 10, UNM = 11, SWT = 12;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, priv = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, err;
  core_evt_s evt = '0;
  core_evt_s base = '0;
  core_resp_s resp;
  logic [31:0] mdl [0:7];
  // group mask of each grouping code
  logic [3:0] gm [0:7] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
  int bad_count = 0, checks_done = 0, cycles = 0;
  logic [31:0] d;
  logic [7:0] a, pp, ap;
  logic [3:0] s;
  logic [2:0] g;

  core_system_control core_system_control_i (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_priv_i(priv), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .evt(evt), .resp(resp));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one classic cycle, held until ack or err
  task automatic bus(input logic w, input logic [7:0] ad, input logic [3:0] sl, input logic [31:0] dd,
                     input logic pv, output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= sl;
    dat <= dd;
    priv <= pv;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rq = rdat;
    re = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [31:0] wmask(input logic [7:0] ad);
    case (ad)
      OFS_APP_CTRL: return 32'h00000700;
      OFS_LOWPOWER: return LOWPOWER_WR_MASK;
      OFS_CORE_CFG: return CORE_CFG_WR_MASK;
      OFS_FAULT_PRI: return FAULT_PRI_WR_MASK;
      OFS_SVC_PRI: return SVC_PRI_WR_MASK;
      default: return 32'h00000000;
    endcase
  endfunction

  // bus access compared against the register model
  task automatic acc(input logic w, input logic [7:0] ad, input logic [3:0] sl, input logic [31:0] dd,
                     input logic pv);
    logic [31:0] be, mk, x, rq;
    logic re;
    be = {{8{sl[3]}}, {8{sl[2]}}, {8{sl[1]}}, {8{sl[0]}}};
    mk = wmask(ad) & be;
    if (ad == OFS_APP_CTRL && !(sl[3:1] == 3'h7 && dd[31:16] == 16'h05FA)) mk = 32'h00000000;
    x = (ad == OFS_APP_CTRL) ? 32'hFA050000 : 32'h00000000;
    bus(w, ad, sl, dd, pv, rq, re);
    chk("err", re, !pv);
    chk("rdata", rq, (pv && !w) ? (mdl[ad[4:2]] | x) : 32'h00000000);
    if (pv && w) mdl[ad[4:2]] = (mdl[ad[4:2]] & ~mk) | (dd & mk);
  endtask

  task automatic step(input core_evt_s v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= base;
    @(negedge clock);
  endtask

  task automatic p(input int k);
    core_evt_s e;
    e = base;
    case (k)
      WAIT_FOR_EVENT_INSTR: e.wfe_exec = 1'b1;
      SEND_EVENT_INSTR: e.sev_exec = 1'b1;
      EXT: e.ext_event = 1'b1;
      IRQ: e.irq_new_pend = 1'b1;
      SLP: e.sleep_req = 1'b1;
      RET: e.return_to_thread = 1'b1;
      ENT: e.exc_entry = 1'b1;
      XRT: e.exception_return_code = 1'b1;
      BUS: e.data_bus_fault = 1'b1;
      DIV: e.div_zero_exec = 1'b1;
      UNH: e.unal_hw_word = 1'b1;
      UNM: e.unal_multi = 1'b1;
      default: e.unpriv_swt_wr = 1'b1;
    endcase
    step(e);
  endtask

  initial begin
    void'($urandom(2));
    for (int i = 0; i < 8; i++) mdl[i] = 32'h00000000;
    mdl[5] = 32'h00000200;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 3; i < 9; i++) acc(1'b0, 8'(i * 4), 4'hF, 32'h00000000, 1'b1);
    for (int i = 0; i < 40; i++) begin
      a = 8'(($urandom % 6 + 3) * 4);
      d = $urandom;
      if (a == OFS_LOWPOWER) d = d & LOWPOWER_WR_MASK;
      if ($urandom % 2) d[31:16] = 16'h05FA;
      s = ($urandom % 2) ? 4'hF : 4'(1 << ($urandom % 4));
      acc(1'b1, a, s, d, ($urandom % 4) != 0);
      acc(1'b0, a, 4'hF, 32'h00000000, ($urandom % 5) != 0);
    end
    for (int i = 0; i < 32; i++) begin
      g = 3'(i);
      acc(1'b1, OFS_APP_CTRL, 4'hF, {16'h05FA, 5'h00, g, 8'h00}, 1'b1);
      pp = 8'($urandom);
      ap = i[3] ? 8'($urandom) : pp ^ {~gm[g] & 4'($urandom), 4'h0};
      base.pend_prio = pp;
      base.act_prio = ap;
      base.act_valid = (i % 7) != 0;
      step(base);
      chk("preempt", resp.preempt, !base.act_valid || (pp[7:4] & gm[g]) < (ap[7:4] & gm[g]));
    end
    acc(1'b1, OFS_LOWPOWER, 4'hF, 32'h00000000, 1'b1);
    p(WAIT_FOR_EVENT_INSTR);
    chk("waiting", resp.wfe_waiting, 1);
    p(IRQ);
    chk("wake", resp.wake, 0);
    acc(1'b1, OFS_LOWPOWER, 4'hF, 32'h00000010, 1'b1);
    p(IRQ);
    chk("wake", resp.wake, 1);
    p(EXT);
    p(WAIT_FOR_EVENT_INSTR);
    chk("wake", resp.wake, 1);
    p(WAIT_FOR_EVENT_INSTR);
    p(SEND_EVENT_INSTR);
    chk("wake", resp.wake, 1);
    for (int j = 0; j < 2; j++) begin
      acc(1'b1, OFS_LOWPOWER, 4'hF, j ? 32'h00000004 : 32'h00000000, 1'b1);
      p(SLP);
      chk("lowpower", resp.lowpower, 1);
      chk("deep", resp.deep, j);
      p(EXT);
      acc(1'b1, OFS_LOWPOWER, 4'hF, j ? 32'h00000002 : 32'h00000000, 1'b1);
      p(RET);
      chk("lowpower", resp.lowpower, j);
      p(EXT);
    end
    for (int j = 0; j < 2; j++) begin
      acc(1'b1, OFS_CORE_CFG, 4'hF, j ? 32'h0000031B : 32'h00000000, 1'b1);
      p(DIV);
      chk("div_fault", resp.div_fault, j);
      chk("quotient", resp.div_quotient_zero, !j);
      p(UNH);
      chk("usage", resp.usage_fault, j);
      p(UNM);
      chk("usage", resp.usage_fault, 1);
      p(SWT);
      chk("swt_accept", resp.swt_accept, j);
      chk("swt_refuse", resp.swt_refuse, !j);
      base.other_active = 1'b1;
      p(RET);
      chk("thread_ok", resp.thread_ok, j);
      chk("thread_fault", resp.thread_fault, !j);
      base.other_active = 1'b0;
      base.sp = $urandom;
      p(ENT);
      chk("sp", resp.sp_out, j ? base.sp & ~32'h00000007 : base.sp & ~32'h00000003);
      chk("adjust", resp.stack_adj, j && base.sp[2]);
      base.stacked_adj = 1'b1;
      p(XRT);
      chk("sp", resp.sp_out, base.sp | 32'h00000004);
      base.stacked_adj = 1'b0;
      base.top_handler = 1'b1;
      if (j) p(BUS);
      base.top_handler = 1'b0;
      chk("ignored", resp.bus_fault_ignored, j);
    end
    acc(1'b1, OFS_CORE_CFG, 4'hF, 32'h00000000, 1'b1);
    base.top_handler = 1'b1;
    p(BUS);
    p(SEND_EVENT_INSTR);
    chk("lockup", resp.lockup, 1);
    conclude();
  end
endmodule
